// *** inc/adcr_consts.vh ***
/*
 Constants for the amplifier control register bank: register offsets,
 field positions, reset values and ramp timing.
 Assumes an 8-bit control port with a 7-bit address is decoded upstream.
*/
// Function
// - the switching-frequency field picks 768k, 384k, 310k, 480k, 576k or 1.024M for codes 0 to 5.
// - the bridge bit selects two bridge-tied loads when 0 and one parallel bridge-tied load when 1.
// - the modulation field selects BD (00), single-sided pwm (01) or hybrid (10).
// - the core hold-reset bit resets to 1 and the core runs once software writes it to 0.
// - the mute bit sends a soft-mute request to left and right together, and clearing it restores volume.
// - mute and unmute ramp the gain smoothly rather than stepping it.
// - the power-state field selects deep sleep, sleep, high impedance or play, and resets to deep sleep.
// - with page wrap enabled, a sequential access in a non-zero book past a page end goes to location 8 of the next page.
// - with page wrap disabled, a sequential access past a page end goes to location 0 of the same page.
// - the bit-clock field encodes 32, 64, 128, 256 or 512 bit clocks per frame.
// - the sample-rate field encodes 32, 44.1, 48, 88.2 or 96 kHz, other codes reserved.
// - sample-rate code 0000, the reset value, selects automatic rate detection.
// - writing 1 to the register-reset bit returns all control registers to reset and clears itself.
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// ==========================================================
// offsets
`define ADCR_OFS_RESET 7'h01
`define ADCR_OFS_STAGE 7'h02
`define ADCR_OFS_CORE 7'h03
`define ADCR_OFS_PAGE 7'h0F
`define ADCR_OFS_AUDIO 7'h28

// ==========================================================
// reset values
`define ADCR_RST_STAGE 8'h00
`define ADCR_RST_CORE 8'h10
`define ADCR_RST_PAGE 8'h00
`define ADCR_RST_AUDIO 8'h00

// ==========================================================
// field positions
`define ADCR_BIT_REGRST 0
`define ADCR_BIT_PARALLEL_BRIDGE_LOAD 2
`define ADCR_BIT_HOLD 4
`define ADCR_BIT_MUTE 3
`define ADCR_BIT_WRAPDIS 3
`define ADCR_FSW_LSB 4
`define ADCR_PAGE_START 7'h08
`define ADCR_PAGE_LAST 7'h7F

// ==========================================================
// codes
`define ADCR_FSW_RSV_A 3'h6
`define ADCR_FS_AUTO 4'h0

// ==========================================================
// gain ramp: 1 us per step, 8-bit gain
`define ADCR_RAMP_STEP_NS 1000
`define ADCR_CLK_NS 50
`define ADCR_RAMP_CYC (`ADCR_RAMP_STEP_NS / `ADCR_CLK_NS)
// last tick count of one step, sized for the 5-bit step counter
`define ADCR_RAMP_LAST 5'h13
`define ADCR_GAIN_FULL 8'hFF

`endif

// *** rtl/adcr_gain_ramp.v ***
/*
 Soft gain ramp shared by left and right channels.
 Assumes mute_req is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcr_consts.vh"

module adcr_gain_ramp (
	input wire clk,
	input wire rstn,
	input wire mute_req,
	output reg [7:0] gain_reg,
	output wire ramping
);
	reg [4:0] tick_reg;
	wire [7:0] target;
	wire step;

	assign target = mute_req ? 8'h00 : `ADCR_GAIN_FULL;
	assign ramping = (gain_reg != target);
	assign step = (tick_reg == `ADCR_RAMP_LAST);

	// ==========================================================
	// one lsb per step so the level never jumps
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_reg <= 5'h00;
			gain_reg <= `ADCR_GAIN_FULL;
		end else begin
			tick_reg <= (step || !ramping) ? 5'h00 : tick_reg + 5'h01;
			if (step && ramping) begin
				if (gain_reg < target) begin
					gain_reg <= gain_reg + 8'h01;
				end else begin
					gain_reg <= gain_reg - 8'h01;
				end
			end
		end
	end
endmodule // adcr_gain_ramp
`default_nettype wire

// *** rtl/adcr_regs.v ***
/*
 Control register bank for the class-D amplifier core: output stage,
 core reset, mute and power state, page wrap and audio clock format.
 Assumes the control port supplies synchronous single-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcr_consts.vh"

module adcr_regs (
	input wire clk,
	input wire rstn,
	input wire [6:0] cp_addr,
	input wire [7:0] cp_wdata,
	input wire cp_wr,
	input wire cp_rd,
	output reg [7:0] cp_rdata,
	input wire seq_step,
	input wire book_nonzero,
	input wire [7:0] page_in,
	input wire [6:0] loc_in,
	output reg [7:0] page_next,
	output reg [6:0] loc_next,
	output reg [2:0] switching_freq_select,
	output reg fsw_valid,
	output reg parallel_bridge_select,
	output reg [1:0] modulation_scheme,
	output reg core_hold_reset,
	output reg [1:0] power_state,
	output reg [7:0] left_gain,
	output reg [7:0] right_gain,
	output wire ramp_busy,
	output reg [3:0] bitclk_per_frame,
	output reg [3:0] sample_rate_mode,
	output reg rate_auto_detect
);
	reg [7:0] stage_reg;
	reg [7:0] core_reg;
	reg [7:0] page_reg;
	reg [7:0] audio_reg;
	reg [7:0] rdata_next;
	wire reg_reset;
	wire [7:0] gain;

	// ==========================================================
	// register-reset bit reads back as 0: it is a pulse only
	assign reg_reset = cp_wr && (cp_addr == `ADCR_OFS_RESET)
		&& cp_wdata[`ADCR_BIT_REGRST];

	// ==========================================================
	// register writes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage_reg <= `ADCR_RST_STAGE;
			core_reg <= `ADCR_RST_CORE;
			page_reg <= `ADCR_RST_PAGE;
			audio_reg <= `ADCR_RST_AUDIO;
		end else if (reg_reset) begin
			stage_reg <= `ADCR_RST_STAGE;
			core_reg <= `ADCR_RST_CORE;
			page_reg <= `ADCR_RST_PAGE;
			audio_reg <= `ADCR_RST_AUDIO;
		end else if (cp_wr) begin
			case (cp_addr)
				`ADCR_OFS_STAGE: stage_reg <= cp_wdata;
				`ADCR_OFS_CORE: core_reg <= cp_wdata;
				`ADCR_OFS_PAGE: page_reg <= cp_wdata;
				`ADCR_OFS_AUDIO: audio_reg <= cp_wdata;
				default: stage_reg <= stage_reg;
			endcase
		end
	end

	// ==========================================================
	// read back
	always @* begin
		case (cp_addr)
			`ADCR_OFS_STAGE: rdata_next = stage_reg;
			`ADCR_OFS_CORE: rdata_next = core_reg;
			`ADCR_OFS_PAGE: rdata_next = page_reg;
			`ADCR_OFS_AUDIO: rdata_next = audio_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cp_rdata <= 8'h00;
		end else if (cp_rd) begin
			cp_rdata <= rdata_next;
		end
	end

	// ==========================================================
	// decoded controls, registered so outputs come from flip-flops
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			switching_freq_select <= 3'h0;
			fsw_valid <= 1'b1;
			parallel_bridge_select <= 1'b0;
			modulation_scheme <= 2'h0;
			core_hold_reset <= 1'b1;
			power_state <= 2'h0;
			bitclk_per_frame <= 4'h0;
			sample_rate_mode <= 4'h0;
			rate_auto_detect <= 1'b1;
			left_gain <= `ADCR_GAIN_FULL;
			right_gain <= `ADCR_GAIN_FULL;
		end else begin
			switching_freq_select <= stage_reg[`ADCR_FSW_LSB+2:`ADCR_FSW_LSB];
			// reserved codes 6 and 7 flagged by fsw_valid low; switching_freq_select still takes the new code
			fsw_valid <= (stage_reg[`ADCR_FSW_LSB+2:`ADCR_FSW_LSB] < `ADCR_FSW_RSV_A);
			parallel_bridge_select <= stage_reg[`ADCR_BIT_PARALLEL_BRIDGE_LOAD];
			modulation_scheme <= stage_reg[1:0];
			core_hold_reset <= core_reg[`ADCR_BIT_HOLD];
			power_state <= core_reg[1:0];
			bitclk_per_frame <= audio_reg[7:4];
			sample_rate_mode <= audio_reg[3:0];
			rate_auto_detect <= (audio_reg[3:0] == `ADCR_FS_AUTO);
			left_gain <= gain;
			right_gain <= gain;
		end
	end

	// one ramp drives both channels so they stay matched
	adcr_gain_ramp u_ramp (
		.clk(clk),
		.rstn(rstn),
		.mute_req(core_reg[`ADCR_BIT_MUTE]),
		.gain_reg(gain),
		.ramping(ramp_busy)
	);

	// ==========================================================
	// sequential address advance for the coefficient memory
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_next <= 8'h00;
			loc_next <= 7'h00;
		end else if (seq_step) begin
			if (loc_in != `ADCR_PAGE_LAST) begin
				page_next <= page_in;
				loc_next <= loc_in + 7'h01;
			end else if (page_reg[`ADCR_BIT_WRAPDIS] || !book_nonzero) begin
				page_next <= page_in;
				loc_next <= 7'h00;
			end else begin
				page_next <= page_in + 8'h01;
				loc_next <= `ADCR_PAGE_START;
			end
		end
	end
endmodule // adcr_regs
`default_nettype wire

// *** verif/adcr_regs_sva.sv ***
/* Port checker for adcr_regs.
 Assumes one clock domain; bound by name below. */
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_sva (
	input wire clk,
	input wire rstn,
	input wire [6:0] cp_addr,
	input wire [7:0] cp_wdata,
	input wire cp_wr,
	input wire cp_rd,
	input wire [7:0] cp_rdata,
	input wire seq_step,
	input wire [6:0] loc_in,
	input wire [6:0] loc_next,
	input wire [2:0] switching_freq_select,
	input wire fsw_valid,
	input wire core_hold_reset,
	input wire [7:0] left_gain,
	input wire [7:0] right_gain
);
	// ====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_FSW: assert property (cp_wr && cp_addr == 7'h02 |->
		##2 switching_freq_select == $past(cp_wdata[6:4], 2)) else $error("fsw");
	AST_RSV: assert property (fsw_valid == (switching_freq_select < 3'h6))
		else $error("fsw_valid");
	AST_HOLD: assert property (cp_wr && cp_addr == 7'h03 |->
		##2 core_hold_reset == $past(cp_wdata[4], 2)) else $error("hold");
	AST_PAIR: assert property ($past(rstn) |-> left_gain == right_gain)
		else $error("gain pair");
	// one step at a time, so no audible jump
	AST_RAMP: assert property ($past(rstn, 2) && $changed(left_gain) |->
		left_gain - $past(left_gain) == 8'h01 || $past(left_gain) - left_gain == 8'h01)
		else $error("gain step");
	AST_SEQ: assert property (seq_step && loc_in != 7'h7F |=>
		loc_next == $past(loc_in) + 7'h01) else $error("seq");
	AST_CTL: assert property (cp_rd && cp_addr == 7'h01 |=> cp_rdata == 8'h00)
		else $error("reset reg read");
	AST_RDBK: assert property (cp_wr && cp_addr == 7'h0F ##1 cp_rd && cp_addr == 7'h0F
		|=> cp_rdata == $past(cp_wdata, 2)) else $error("readback");
	cover property (seq_step && loc_in == 7'h7F);
	cover property (left_gain == 8'h00);
	cover property (cp_wr && cp_addr == 7'h01 && cp_wdata[0]);
endmodule // adcr_regs_sva
bind adcr_regs adcr_regs_sva u_adcr_regs_sva (.*);
`default_nettype wire

// *** verif/adcr_regs_test.sv ***
/* Bench for adcr_regs against a register model.
 Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_test;
	logic clk, rstn, cp_wr, cp_rd, seq_step, book_nonzero;
	logic [6:0] cp_addr, loc_in, a;
	logic [7:0] cp_wdata, page_in, v;
	logic [14:0] e;
	wire [7:0] cp_rdata, page_next, left_gain, right_gain;
	wire [6:0] loc_next;
	wire [2:0] switching_freq_select;
	wire [1:0] modulation_scheme, power_state;
	wire [3:0] bitclk_per_frame, sample_rate_mode;
	wire fsw_valid, parallel_bridge_select, core_hold_reset, ramp_busy, rate_auto_detect;
	integer bad_count = 0, total_checks = 0, k, n;
	logic [7:0] m [0:127];
	logic [6:0] al [0:5] = '{7'h01, 7'h02, 7'h03, 7'h0F, 7'h28, 7'h64};
	adcr_regs u_adcr_regs (.*);
	// ====
	// tasks
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, x, s);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	task wr(input logic [6:0] ad, input logic [7:0] d);
		cp_addr = ad;
		cp_wdata = d;
		cp_wr = 1;
		tick;
		cp_wr = 0;
		if (ad == 7'h01 && d[0]) begin
			{m[2], m[3], m[15], m[40]} = 32'h00100000;
		end else if (ad inside {7'h02, 7'h03, 7'h0F, 7'h28}) m[ad] = d;
	endtask
	task rdchk(input logic [6:0] ad);
		cp_addr = ad;
		cp_rd = 1;
		tick;
		cp_rd = 0;
		chk("rdata", cp_rdata, m[ad]);
	endtask
	task outchk;
		chk("fsw", {fsw_valid, switching_freq_select}, {m[2][6:4] < 3'h6, m[2][6:4]});
		chk("stage", {parallel_bridge_select, modulation_scheme}, m[2][2:0]);
		chk("core", {core_hold_reset, power_state}, {m[3][4], m[3][1:0]});
		chk("audio", {bitclk_per_frame, sample_rate_mode, rate_auto_detect},
			{m[40], m[40][3:0] == 4'h0});
	endtask
	task wait_gain(input logic [7:0] g);
		n = 0;
		while (left_gain !== g && n < 6000) begin
			tick;
			n++;
		end
		if (n == 6000) begin
			chk("timeout", 0, 1);
			results;
		end
	endtask
	// ====
	// sequence
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rstn, cp_wr, cp_rd, seq_step, book_nonzero, cp_addr, cp_wdata, page_in, loc_in} = 0;
		for (k = 0; k < 128; k++) m[k] = 8'h00;
		m[3] = 8'h10;
		v = $urandom(59853);
		repeat (16) @(posedge clk);
		#1 rstn = 1;
		tick;
		for (k = 0; k < 6; k++) rdchk(al[k]);
		outchk;
		$display("reset test done");
		for (k = 0; k < 64; k++) begin
			a = al[$urandom % 6];
			v = $urandom;
			if (a == 7'h02) v[6:4] = k[2:0];
			wr(a, v);
			rdchk(a);
			outchk;
		end
		$display("random test done");
		for (k = 1; k < 5; k++) wr(al[k], 8'hFF);
		wr(7'h01, 8'h01);
		for (k = 0; k < 5; k++) rdchk(al[k]);
		outchk;
		$display("soft reset test done");
		for (k = 0; k < 8; k++) begin
			book_nonzero = k[0];
			wr(7'h0F, {4'h0, k[1], 3'h0});
			page_in = $urandom;
			loc_in = k[2] ? 7'h7F : 7'($urandom % 127);
			seq_step = 1;
			tick;
			seq_step = 0;
			e = {page_in, loc_in + 7'h01};
			if (loc_in == 7'h7F) e = (k[0] && !k[1]) ? {page_in + 8'h01, 7'h08} : {page_in, 7'h00};
			chk("next_addr", {page_next, loc_next}, e);
		end
		$display("page test done");
		wr(7'h28, 8'h59);
		rdchk(7'h28);
		outchk;
		wr(7'h03, 8'h03);
		wait_gain(8'hFF);
		wr(7'h03, 8'h0B);
		wait_gain(8'h00);
		chk("mute_time", n > 5000 && n < 5200, 1);
		chk("right_gain", right_gain, 0);
		wr(7'h03, 8'h03);
		wait_gain(8'hFF);
		chk("unmute_time", n > 5000 && n < 5200, 1);
		chk("ramp_busy", ramp_busy, 0);
		$display("mute test done");
		results;
	end
endmodule // adcr_regs_test
`default_nettype wire
